// *** src/fcs_combiner.sv ***
// Purpose: combines two operand frequencies and the offset into a command
// Assumes: operands in 0.01 Hz units, signed 32 bit
// Notes:   multiply result is truncated to 32 bits
`timescale 1ns/10ps
`default_nettype none
module fcs_combiner
    import fcs_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire fcs_op_t            oper,
    input  wire logic               offset_sub,
    input  wire logic        [31:0] offset_freq,
    input  wire logic signed [31:0] operand_one,
    input  wire logic signed [31:0] operand_two,
    output logic signed      [31:0] freq_cmd
);
    wire logic signed [63:0] prod_full = operand_one * operand_two;
    wire logic signed [31:0] ofs_s     = $signed(offset_freq);
    logic signed [31:0] base;

    always_comb
    begin
        case (oper)
            FCS_OP_ADD: base = operand_one + operand_two; // R8
            FCS_OP_SUB: base = operand_one - operand_two; // R8
            FCS_OP_MUL: base = prod_full[31:0];           // R8
            default:    base = operand_one;
        endcase
    end

    wire logic signed [31:0] next_freq_cmd = offset_sub ? base - ofs_s : base + ofs_s; // R10

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            freq_cmd <= '0;
        else
            freq_cmd <= next_freq_cmd;
    end
endmodule
`default_nettype wire

// *** src/fcs_pkg.sv ***
// Purpose: constants and types for the frequency-command setup register bank
// Assumes: 16-bit word registers, word addresses as printed
// Notes:   numeric limits are held here so the bank and its checks share them
//
// What this block does
// [R1] current-input start/end frequency: 0..40000, split hi word at lower address
// [R2] current-input start pct 0..end pct; end pct start pct..100
// [R3] current-input start select: 0 external start frequency, 1 zero hertz
// [R4] bipolar-input start/end frequency: signed -40000..40000, hi/lo word pair
// [R5] bipolar-input start pct -100..end pct; end pct start pct..100
// [R6] accel and decel curve constants accept 1..10
// [R7] operand sources encode 0..7: operator, pot, voltage, current, comms, opt1, opt2, pulse
// [R8] operator: 0 add, 1 subtract second from first, 2 multiply
// [R9] offset frequency: unsigned 0..40000, hi/lo word pair
// [R10] offset sign: 00 adds offset, 01 subtracts offset
// [R11] extended s-curve accel ratios accept 0..50
// [R12] extended s-curve decel ratios accept 0..50
// [R13] curve shape encoding: 0 linear, 1 s, 2 u, 3 inverted u, 4 extended s
// [R14] reserved addresses in range never change any stored parameter
package fcs_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NREG   = 26;

    localparam logic [15:0] REG_RSVD        = 16'h1280;
    localparam logic [15:0] REG_CUR_SF_HI   = 16'h1281;
    localparam logic [15:0] REG_CUR_SF_LO   = 16'h1282;
    localparam logic [15:0] REG_CUR_EF_HI   = 16'h1283;
    localparam logic [15:0] REG_CUR_EF_LO   = 16'h1284;
    localparam logic [15:0] REG_CUR_SP      = 16'h1285;
    localparam logic [15:0] REG_CUR_EP      = 16'h1286;
    localparam logic [15:0] REG_CUR_SEL     = 16'h1287;
    localparam logic [15:0] REG_BIP_SF_HI   = 16'h128d;
    localparam logic [15:0] REG_BIP_SF_LO   = 16'h128e;
    localparam logic [15:0] REG_BIP_EF_HI   = 16'h128f;
    localparam logic [15:0] REG_BIP_EF_LO   = 16'h1290;
    localparam logic [15:0] REG_BIP_SP      = 16'h1291;
    localparam logic [15:0] REG_BIP_EP      = 16'h1292;
    localparam logic [15:0] REG_ACC_CONST   = 16'h12a5;
    localparam logic [15:0] REG_DEC_CONST   = 16'h12a6;
    localparam logic [15:0] REG_SRC_ONE     = 16'h12af;
    localparam logic [15:0] REG_SRC_TWO     = 16'h12b0;
    localparam logic [15:0] REG_OPERATOR    = 16'h12b1;
    localparam logic [15:0] REG_OFS_HI      = 16'h12b3;
    localparam logic [15:0] REG_OFS_LO      = 16'h12b4;
    localparam logic [15:0] REG_OFS_SIGN    = 16'h12b5;
    localparam logic [15:0] REG_ACC_R1      = 16'h12b9;
    localparam logic [15:0] REG_ACC_R2      = 16'h12ba;
    localparam logic [15:0] REG_DEC_R1      = 16'h12bb;
    localparam logic [15:0] REG_DEC_R2      = 16'h12bc;
    localparam logic [15:0] REG_RANGE_LAST  = 16'h1300;

    localparam logic signed [31:0] FREQ_MAX = 32'sd40000;
    localparam logic signed [31:0] FREQ_MIN_SIGNED = -32'sd40000;
    localparam logic signed [15:0] PCT_MAX  = 16'sd100;
    localparam logic signed [15:0] PCT_MIN_SIGNED = -16'sd100;
    localparam logic [15:0] CURVE_MIN  = 16'h0001;
    localparam logic [15:0] CURVE_MAX  = 16'h000a;
    localparam logic [15:0] SRC_MAX    = 16'h0007;
    localparam logic [15:0] OP_MAX     = 16'h0002;
    localparam logic [15:0] SEL_MAX    = 16'h0001;
    localparam logic [15:0] RATIO_MAX  = 16'h0032;
    localparam logic [15:0] SHAPE_MAX  = 16'h0004;

    // reset values: zero for most fields, 100 for the end percentages, 1 for the curve constants
    localparam logic [15:0] RST_ZERO   = 16'h0000;
    localparam logic [15:0] RST_PCT_HI = 16'h0064;
    localparam logic [15:0] RST_CURVE  = 16'h0001;

    typedef enum logic [2:0] {
        FCS_SRC_OPERATOR, FCS_SRC_POT, FCS_SRC_VOLT, FCS_SRC_CUR,
        FCS_SRC_COMMS, FCS_SRC_OPT1, FCS_SRC_OPT2, FCS_SRC_PULSE
    } fcs_src_t;

    typedef enum logic [1:0] {FCS_OP_ADD, FCS_OP_SUB, FCS_OP_MUL, FCS_OP_NONE} fcs_op_t;

    typedef enum logic [2:0] {
        FCS_SHAPE_LINEAR, FCS_SHAPE_S, FCS_SHAPE_U, FCS_SHAPE_INV_U, FCS_SHAPE_EXT_S // R13
    } fcs_shape_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } fcs_req_t;

    typedef struct packed {
        logic        [31:0] cur_start_freq;
        logic        [31:0] cur_end_freq;
        logic        [7:0]  cur_start_pct;
        logic        [7:0]  cur_end_pct;
        logic               cur_zero_below;
        logic signed [31:0] bip_start_freq;
        logic signed [31:0] bip_end_freq;
        logic signed [7:0]  bip_start_pct;
        logic signed [7:0]  bip_end_pct;
        logic        [3:0]  accel_const;
        logic        [3:0]  decel_const;
        fcs_src_t           src_one;
        fcs_src_t           src_two;
        fcs_op_t            oper;
        logic        [31:0] offset_freq;
        logic               offset_sub;
        logic        [5:0]  acc_ratio_one;
        logic        [5:0]  acc_ratio_two;
        logic        [5:0]  dec_ratio_one;
        logic        [5:0]  dec_ratio_two;
    } fcs_cfg_t;
endpackage

// *** src/fcs_regs.sv ***
// Purpose: frequency-command setup parameter register bank with operand combiner
// Assumes: word-addressed port, read data one cycle after read strobe
// Notes:   out-of-range writes are dropped whole, the old value stays
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fcs_regs
    import fcs_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic signed [31:0] src_freq_in [8],
    output logic      [DATA_W-1:0]  reg_rdata,
    output logic                    wr_rejected,
    output fcs_cfg_t                cfg,
    output logic signed [31:0]      freq_cmd
);
    fcs_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    localparam logic [15:0] MAP_ADDR [NREG] = '{
        REG_CUR_SF_HI, REG_CUR_SF_LO, REG_CUR_EF_HI, REG_CUR_EF_LO, REG_CUR_SP,
        REG_CUR_EP, REG_CUR_SEL, REG_BIP_SF_HI, REG_BIP_SF_LO, REG_BIP_EF_HI,
        REG_BIP_EF_LO, REG_BIP_SP, REG_BIP_EP, REG_ACC_CONST, REG_DEC_CONST,
        REG_SRC_ONE, REG_SRC_TWO, REG_OPERATOR, REG_OFS_HI, REG_OFS_LO,
        REG_OFS_SIGN, REG_ACC_R1, REG_ACC_R2, REG_DEC_R1, REG_DEC_R2, REG_RSVD};
    localparam int I_CSF_H = 0, I_CSF_L = 1, I_CEF_H = 2, I_CEF_L = 3, I_CSP = 4;
    localparam int I_CEP = 5, I_CSEL = 6, I_BSF_H = 7, I_BSF_L = 8, I_BEF_H = 9;
    localparam int I_BEF_L = 10, I_BSP = 11, I_BEP = 12, I_ACC = 13, I_DEC = 14;
    localparam int I_S1 = 15, I_S2 = 16, I_OP = 17, I_OF_H = 18, I_OF_L = 19;
    localparam int I_OSGN = 20, I_AR1 = 21, I_AR2 = 22, I_DR1 = 23, I_DR2 = 24;
    localparam int NSTORE = 25;

    logic [DATA_W-1:0] regs [NSTORE];
    logic [NREG-1:0]   hit;

    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_dec
            assign hit[g] = (req.addr == MAP_ADDR[g]);
        end
    endgenerate

    wire logic any_hit = |hit[NSTORE-1:0];

    // one-hot to index
    logic [4:0] idx;
    always_comb
    begin
        idx = '0;
        for (int i = 0; i < NSTORE; i++)
            if (hit[i])
                idx = 5'(i);
    end

    // candidate 32-bit values when one half of a pair is written
    wire logic [15:0] w = req.wdata;
    wire logic [31:0] cur_sf_new = hit[I_CSF_H] ? {w, regs[I_CSF_L]} : {regs[I_CSF_H], w};
    wire logic [31:0] cur_ef_new = hit[I_CEF_H] ? {w, regs[I_CEF_L]} : {regs[I_CEF_H], w};
    wire logic [31:0] bip_sf_new = hit[I_BSF_H] ? {w, regs[I_BSF_L]} : {regs[I_BSF_H], w};
    wire logic [31:0] bip_ef_new = hit[I_BEF_H] ? {w, regs[I_BEF_L]} : {regs[I_BEF_H], w};
    wire logic [31:0] ofs_new    = hit[I_OF_H] ? {w, regs[I_OF_L]} : {regs[I_OF_H], w};

    // hi word alone may transiently hold an odd pair; the check is on the joined value,
    // so software must write the half that keeps the pair legal first
    wire logic ok_u_freq = ($signed(cur_sf_new) >= 0) && ($signed(cur_sf_new) <= FREQ_MAX); // R1
    wire logic ok_u_efrq = ($signed(cur_ef_new) >= 0) && ($signed(cur_ef_new) <= FREQ_MAX); // R1
    wire logic ok_b_sf   = ($signed(bip_sf_new) >= FREQ_MIN_SIGNED) && ($signed(bip_sf_new) <= FREQ_MAX); // R4
    wire logic ok_b_ef   = ($signed(bip_ef_new) >= FREQ_MIN_SIGNED) && ($signed(bip_ef_new) <= FREQ_MAX); // R4
    wire logic ok_ofs    = ($signed(ofs_new) >= 0) && ($signed(ofs_new) <= FREQ_MAX); // R9
    wire logic ok_csp    = ($signed(w) >= 0) && ($signed(w) <= $signed(regs[I_CEP])); // R2
    wire logic ok_cep    = ($signed(w) >= $signed(regs[I_CSP])) && ($signed(w) <= PCT_MAX); // R2
    wire logic ok_bsp    = ($signed(w) >= PCT_MIN_SIGNED) && ($signed(w) <= $signed(regs[I_BEP])); // R5
    wire logic ok_bep    = ($signed(w) >= $signed(regs[I_BSP])) && ($signed(w) <= PCT_MAX); // R5
    wire logic ok_curve  = (w >= CURVE_MIN) && (w <= CURVE_MAX); // R6
    wire logic ok_ratio  = (w <= RATIO_MAX);                     // R11 R12

    logic ok;
    always_comb
    begin
        ok = 1'b0;
        if (hit[I_CSF_H] || hit[I_CSF_L])
            ok = ok_u_freq;
        else if (hit[I_CEF_H] || hit[I_CEF_L])
            ok = ok_u_efrq;
        else if (hit[I_BSF_H] || hit[I_BSF_L])
            ok = ok_b_sf;
        else if (hit[I_BEF_H] || hit[I_BEF_L])
            ok = ok_b_ef;
        else if (hit[I_OF_H] || hit[I_OF_L])
            ok = ok_ofs;
        else if (hit[I_CSP])
            ok = ok_csp;
        else if (hit[I_CEP])
            ok = ok_cep;
        else if (hit[I_BSP])
            ok = ok_bsp;
        else if (hit[I_BEP])
            ok = ok_bep;
        else if (hit[I_CSEL] || hit[I_OSGN])
            ok = (w <= SEL_MAX); // R3 R10
        else if (hit[I_ACC] || hit[I_DEC])
            ok = ok_curve;
        else if (hit[I_S1] || hit[I_S2])
            ok = (w <= SRC_MAX); // R7
        else if (hit[I_OP])
            ok = (w <= OP_MAX);  // R8
        else if (hit[I_AR1] || hit[I_AR2] || hit[I_DR1] || hit[I_DR2])
            ok = ok_ratio;
    end

    // reserved and unmapped addresses never reach the store
    wire logic do_wr = req.wr && any_hit && ok; // R14

    function automatic logic [15:0] rst_val(input int i);
        if (i == I_CEP || i == I_BEP)
            return RST_PCT_HI;
        if (i == I_ACC || i == I_DEC)
            return RST_CURVE;
        return RST_ZERO;
    endfunction

    generate
        for (g = 0; g < NSTORE; g++)
        begin : g_reg
            always_ff @(posedge sys_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    regs[g] <= rst_val(g);
                else if (do_wr && hit[g])
                    regs[g] <= w;
            end
        end
    endgenerate

    // reads of reserved or unmapped words return zero
    wire logic [15:0] next_reg_rdata = (req.rd && any_hit) ? regs[idx] : RST_ZERO;
    wire logic        next_rejected  = req.wr && !do_wr;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata   <= '0;
            wr_rejected <= 1'b0;
        end
        else
        begin
            reg_rdata   <= next_reg_rdata;
            wr_rejected <= next_rejected;
        end
    end

    fcs_cfg_t next_cfg;
    always_comb
    begin
        next_cfg                = '0;
        next_cfg.cur_start_freq = {regs[I_CSF_H], regs[I_CSF_L]}; // R1
        next_cfg.cur_end_freq   = {regs[I_CEF_H], regs[I_CEF_L]}; // R1
        next_cfg.cur_start_pct  = regs[I_CSP][7:0];
        next_cfg.cur_end_pct    = regs[I_CEP][7:0];
        next_cfg.cur_zero_below = regs[I_CSEL][0];                // R3
        next_cfg.bip_start_freq = {regs[I_BSF_H], regs[I_BSF_L]}; // R4
        next_cfg.bip_end_freq   = {regs[I_BEF_H], regs[I_BEF_L]}; // R4
        next_cfg.bip_start_pct  = regs[I_BSP][7:0];
        next_cfg.bip_end_pct    = regs[I_BEP][7:0];
        next_cfg.accel_const    = regs[I_ACC][3:0];
        next_cfg.decel_const    = regs[I_DEC][3:0];
        next_cfg.src_one        = fcs_src_t'(regs[I_S1][2:0]);
        next_cfg.src_two        = fcs_src_t'(regs[I_S2][2:0]);
        next_cfg.oper           = fcs_op_t'(regs[I_OP][1:0]);
        next_cfg.offset_freq    = {regs[I_OF_H], regs[I_OF_L]};   // R9
        next_cfg.offset_sub     = regs[I_OSGN][0];                // R10
        next_cfg.acc_ratio_one  = regs[I_AR1][5:0];               // R11
        next_cfg.acc_ratio_two  = regs[I_AR2][5:0];               // R11
        next_cfg.dec_ratio_one  = regs[I_DR1][5:0];               // R12
        next_cfg.dec_ratio_two  = regs[I_DR2][5:0];               // R12
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cfg <= '0;
        else
            cfg <= next_cfg;
    end

    // operand selection by source code
    wire logic signed [31:0] op_one = src_freq_in[cfg.src_one]; // R7
    wire logic signed [31:0] op_two = src_freq_in[cfg.src_two]; // R7

    fcs_combiner u_comb (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .oper        (cfg.oper),
        .offset_sub  (cfg.offset_sub),
        .offset_freq (cfg.offset_freq),
        .operand_one (op_one),
        .operand_two (op_two),
        .freq_cmd    (freq_cmd)
    );

    // checks
    // a store change at the taking edge shows in cfg one edge later; a legal write just
    // before the reserved one may still ripple into the first edge, so skip that one
    a_rsvd_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
        (req.wr && !any_hit) |=> ##1 $stable(cfg))
        else $error("reserved write changed a parameter");
    a_freq_range: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1 R9
        (cfg.cur_start_freq <= FREQ_MAX) && (cfg.offset_freq <= FREQ_MAX))
        else $error("unsigned frequency out of range");
    a_bip_range: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
        ($signed(cfg.bip_start_freq) >= FREQ_MIN_SIGNED) && ($signed(cfg.bip_end_freq) <= FREQ_MAX))
        else $error("bipolar frequency out of range");
    a_cur_pct_order: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        cfg.cur_start_pct <= cfg.cur_end_pct && cfg.cur_end_pct <= 8'd100)
        else $error("current pct order broken");
    a_bip_pct_order: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        cfg.bip_start_pct <= cfg.bip_end_pct && cfg.bip_start_pct >= -8'sd100)
        else $error("bipolar pct order broken");
    // cfg still shows its cleared value at the first edge after reset
    a_curve_const: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
        !$past(sys_rst) |->
            cfg.accel_const >= CURVE_MIN && cfg.accel_const <= CURVE_MAX && cfg.decel_const >= CURVE_MIN)
        else $error("curve constant out of range");
    a_ratio_limit: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11 R12
        cfg.acc_ratio_one <= 6'd50 && cfg.dec_ratio_two <= 6'd50)
        else $error("ratio out of range");
    a_oper_code: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        cfg.oper != FCS_OP_NONE)
        else $error("illegal operator code stored");
    a_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
        (req.wr && hit[I_CSEL] && w == 16'h0001) |=> ##1 cfg.cur_zero_below)
        else $error("start select write lost");
    a_read_empty: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
        (req.rd && !any_hit) |=> reg_rdata == 16'h0000)
        else $error("reserved read not zero");

    c_ofs_sub: cover property (@(posedge sys_clk) do_wr && hit[I_OSGN] && w == 16'h0001);
    c_reject: cover property (@(posedge sys_clk) wr_rejected);
    c_mul: cover property (@(posedge sys_clk) cfg.oper == FCS_OP_MUL);
    c_rsvd_access: cover property (@(posedge sys_clk) req.wr && hit[NREG-1]);
endmodule
`default_nettype wire

// *** test/fcs_master_model.sv ***
// Purpose: external communication master that reads and writes the parameter bank
// Assumes: strobes one cycle long, read data valid only in the cycle after the strobe
// Notes:   idle address shows the inverse of the last value; idle data is inverted after a write only
`timescale 1ns/10ps
`default_nettype none
module fcs_master_model
    import fcs_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              wr_rejected,
    output var  logic [ADDR_W-1:0] reg_addr,
    output var  logic [DATA_W-1:0] reg_wdata,
    output var  logic              reg_wr,
    output var  logic              reg_rd
);
    initial
    begin
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // the rejection pulse stands one cycle only, so it is sampled just after the taking edge
    task automatic wr_word(input logic [15:0] a, input logic [15:0] d, output logic rej);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
        rej = wr_rejected;
    endtask

    task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/tb_freq_command_setup_regs.sv ***
// Purpose: self-checking bench for the frequency-command setup register bank
// Assumes: rows run in order, each row sees the store left by the rows above it
// Notes:   register access goes through the master model's tasks
`timescale 1ns/10ps
`default_nettype none
module tb_freq_command_setup_regs
    import fcs_pkg::*;
;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        rej;
        logic [15:0] rdbk;
    } fcs_row_t;

    logic               sys_clk;
    logic               sys_rst;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic signed [31:0] src_freq [8];
    logic [DATA_W-1:0]  reg_rdata;
    logic               wr_rejected;
    fcs_cfg_t           cfg;
    logic signed [31:0] freq_cmd;
    int                 n_mismatch;
    int                 n_checks;
    logic               rej;
    logic [15:0]        rd;
    int                 base;
    int                 expv;

    fcs_row_t rows [34] = '{
        '{16'h1281, 16'h0000, 1'b0, 16'h0000}, '{16'h1282, 16'h9c40, 1'b0, 16'h9c40},
        '{16'h1282, 16'h9c41, 1'b1, 16'h9c40}, '{16'h1281, 16'h0001, 1'b1, 16'h0000},
        '{16'h1284, 16'h9c40, 1'b0, 16'h9c40}, '{16'h1285, 16'h0064, 1'b0, 16'h0064},
        '{16'h1286, 16'h0063, 1'b1, 16'h0064}, '{16'h1285, 16'h0065, 1'b1, 16'h0064},
        '{16'h1285, 16'h0005, 1'b0, 16'h0005}, '{16'h1287, 16'h0001, 1'b0, 16'h0001},
        '{16'h1287, 16'h0002, 1'b1, 16'h0001}, '{16'h128e, 16'h63c0, 1'b0, 16'h63c0},
        '{16'h128d, 16'hffff, 1'b0, 16'hffff}, '{16'h128e, 16'h63bf, 1'b1, 16'h63c0},
        '{16'h1291, 16'hff9c, 1'b0, 16'hff9c}, '{16'h1291, 16'hff9b, 1'b1, 16'hff9c},
        '{16'h1292, 16'hff9b, 1'b1, 16'h0064}, '{16'h12a5, 16'h000a, 1'b0, 16'h000a},
        '{16'h12a5, 16'h000b, 1'b1, 16'h000a}, '{16'h12a6, 16'h0000, 1'b1, 16'h0001},
        '{16'h12af, 16'h0007, 1'b0, 16'h0007}, '{16'h12b0, 16'h0008, 1'b1, 16'h0000},
        '{16'h12b1, 16'h0002, 1'b0, 16'h0002}, '{16'h12b1, 16'h0003, 1'b1, 16'h0002},
        '{16'h12b4, 16'h9c40, 1'b0, 16'h9c40}, '{16'h12b5, 16'h0001, 1'b0, 16'h0001},
        '{16'h12b5, 16'h0002, 1'b1, 16'h0001}, '{16'h12b9, 16'h0032, 1'b0, 16'h0032},
        '{16'h12ba, 16'h0033, 1'b1, 16'h0000}, '{16'h12bb, 16'h0032, 1'b0, 16'h0032},
        '{16'h12bc, 16'h0033, 1'b1, 16'h0000}, '{16'h1280, 16'h0001, 1'b1, 16'h0000},
        '{16'h1293, 16'h0001, 1'b1, 16'h0000}, '{16'h1300, 16'h0001, 1'b1, 16'h0000}
    };

    fcs_regs u_dut (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .src_freq_in (src_freq),
        .reg_rdata   (reg_rdata),
        .wr_rejected (wr_rejected),
        .cfg         (cfg),
        .freq_cmd    (freq_cmd)
    );

    fcs_master_model u_master (
        .sys_clk     (sys_clk),
        .reg_rdata   (reg_rdata),
        .wr_rejected (wr_rejected),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd)
    );

    task automatic err(input string msg);
        n_mismatch++;
        $display("ERROR t=%0t %s", $time, msg);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(25 * 6000);
        err("watchdog expired");
        finish_test();
    end

    initial
    begin
        n_mismatch = 0;
        n_checks   = 0;
        sys_rst    = 1'b1;
        for (int i = 0; i < 8; i++)
            src_freq[i] = 32'sd0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // reset contents: end percentages at the top, curve constants at their minimum
        u_master.rd_word(16'h1286, rd);
        n_checks++;
        if (rd !== 16'h0064) err("reset current end pct");
        u_master.rd_word(16'h12a6, rd);
        n_checks++;
        if (rd !== 16'h0001) err("reset decel const");
        for (int i = 0; i < 34; i++)
        begin
            u_master.wr_word(rows[i].addr, rows[i].wdata, rej);
            u_master.rd_word(rows[i].addr, rd);
            n_checks += 2;
            if (rej !== rows[i].rej) err($sformatf("row %0d reject flag", i));
            if (rd !== rows[i].rdbk) err($sformatf("row %0d readback", i));
        end
        n_checks += 3;
        if (cfg.bip_start_freq !== -32'sd40000) err("bipolar start freq");
        if (cfg.cur_zero_below !== 1'b1) err("zero below select");
        if (cfg.src_one !== FCS_SRC_PULSE) err("source one code");
        // operand one is source 7 from the rows, operand two is the current input
        @(posedge sys_clk);
        src_freq[7] <= 32'sd1000;
        src_freq[3] <= 32'sd300;
        u_master.wr_word(REG_SRC_TWO, 16'h0003, rej);
        u_master.wr_word(REG_OFS_LO, 16'h0032, rej);
        for (int s = 0; s < 2; s++)
        begin
            u_master.wr_word(REG_OFS_SIGN, 16'(s), rej);
            for (int op = 0; op < 3; op++)
            begin
                u_master.wr_word(REG_OPERATOR, 16'(op), rej);
                repeat (3) @(posedge sys_clk);
                #1;
                base = (op == 0) ? 1300 : (op == 1) ? 700 : 300000;
                expv = (s == 1) ? base - 50 : base + 50;
                n_checks++;
                if (freq_cmd !== 32'(expv)) err($sformatf("freq cmd op %0d sign %0d", op, s));
            end
        end
        // reset again in mid-run: the store must fall back to its reset contents
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        n_checks++;
        if (cfg.accel_const !== 4'h0) err("cfg not cleared in reset");
        sys_rst <= 1'b0;
        u_master.rd_word(REG_ACC_CONST, rd);
        n_checks++;
        if (rd !== 16'h0001) err("accel const after reset");
        finish_test();
    end
endmodule
`default_nettype wire
